/* File: core/periph_select_pin_mux.sv */
// Purpose: peripheral selects, flow control sharing and prog io pins
// Assumes: bus address, space and phase come from the bus unit
// Notes:   selects are active low; outputs but avs_waitrequest_o come straight from flops
`timescale 1ns/1ns
module periph_select_pin_mux #(
   parameter int ADDR_W = 20
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // avalon-mm slave
   input  wire logic [4:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   output logic      [31:0]       avs_readdata_o,
   output logic                   avs_waitrequest_o,
   // processor bus
   input  wire logic [ADDR_W-1:0] bus_addr_i,
   input  wire logic              bus_start_i,
   input  wire logic              bus_io_i,
   input  wire logic              bus_end_i,
   input  wire logic              bus_hold_i,
   input  wire logic              dram_hit_i,
   output logic                   dram_go_o,
   // serial port 1 side
   input  wire logic              tx_pending_i,
   input  wire logic              tx_frame_start_i,
   input  wire logic              rx_full_i,
   output logic                   tx_allowed_o,
   output logic                   rx_enabled_o,
   // pins
   input  wire logic [31:0]       pin_in_i,
   output logic      [31:0]       pin_out_o,
   output logic      [31:0]       pin_oe_o,
   output logic      [31:0]       pin_pull_up_o,
   output logic      [31:0]       pin_pull_dn_o,
   output logic      [31:0]       pin_fn_o
);
   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [ADDR_W-1:0] periph_base;
   logic [4:0]        aux_config_reg;
   logic [31:0]       prog_en;
   logic [31:0]       prog_dir;
   logic [31:0]       prog_pull;
   logic [31:0]       prog_out;
   logic              ack;
   logic              req;
   logic [31:0]       next_rdata;
   logic [6:0]        hit;
   logic              any_hit;
   logic [6:0]        sel_n;
   logic              sel_float;
   logic [1:0]        addr_latch;
   logic              cts_seen;
   logic              flow_ctl_enable;
   logic              rx_sel;
   logic              send_sel;
   logic              extended_select_bit;
   logic              shared_in;
   logic              clear_to_send_port1;
   logic              receive_enable_request_port1;
   logic              request_to_send_port1;
   logic              ready_to_receive_port1;
   logic              shared_out;
   logic [31:0]       next_fn_out;
   logic [31:0]       next_fn_oe;
   logic [31:0]       next_fn_pu;
   pin_mux_pkg::phase_t phase;
   ////////////////////////////////////////////////////////////////////////
   // field views
   assign flow_ctl_enable     = aux_config_reg[pin_mux_pkg::AUX_FLOW_CTL_ENABLE];
   assign rx_sel              = aux_config_reg[pin_mux_pkg::AUX_RX_ENABLE_SELECT];
   assign send_sel            = aux_config_reg[pin_mux_pkg::AUX_SEND_SELECT];
   assign extended_select_bit = aux_config_reg[pin_mux_pkg::AUX_EXTENDED_SELECT];
   assign req                 = avs_read_i | avs_write_i;
   ////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, answer on the second edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end
   assign avs_waitrequest_o = ~(req & ack);
   // register writes, taken at the edge where waitrequest is low
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         periph_base    <= '0;
         aux_config_reg <= pin_mux_pkg::AUX_RESET;
         prog_en        <= pin_mux_pkg::PROG_EN_RESET;
         prog_dir       <= pin_mux_pkg::PROG_DIR_RESET;
         prog_pull      <= pin_mux_pkg::PROG_PULL_RESET;
         prog_out       <= '0;
      end else if (avs_write_i & ack & (avs_address_i[1:0] == 2'b00)) begin
         // unaligned word addresses are unmapped and write nothing
         if (!avs_address_i[4]) begin
            unique case ({avs_address_i[3:2], 2'b00})
               pin_mux_pkg::OFS_PERIPH_BASE:
                  periph_base <= avs_writedata_i[ADDR_W-1:0];
               pin_mux_pkg::OFS_AUX_CONFIG:
                  aux_config_reg <= avs_writedata_i[4:0];
               pin_mux_pkg::OFS_PROG_EN:  prog_en  <= avs_writedata_i;
               pin_mux_pkg::OFS_PROG_DIR: prog_dir <= avs_writedata_i;
               default: ;
            endcase
         end else begin
            unique case ({avs_address_i[3:2], 2'b00})
               pin_mux_pkg::OFS_PROG_PULL: prog_pull <= avs_writedata_i;
               pin_mux_pkg::OFS_PROG_OUT:  prog_out  <= avs_writedata_i;
               default: ;
            endcase
         end
      end
   end
   // read mux; status and pin levels are read only
   always_comb begin
      next_rdata = 32'h0;
      if (!avs_address_i[4]) begin
         unique case ({avs_address_i[3:2], 2'b00})
            pin_mux_pkg::OFS_PERIPH_BASE:
               next_rdata[ADDR_W-1:0] = periph_base;
            pin_mux_pkg::OFS_AUX_CONFIG: next_rdata[4:0] = aux_config_reg;
            pin_mux_pkg::OFS_PROG_EN:    next_rdata = prog_en;
            default:                     next_rdata = prog_dir;
         endcase
      end else begin
         unique case ({avs_address_i[3:2], 2'b00})
            pin_mux_pkg::OFS_PROG_PULL: next_rdata = prog_pull;
            pin_mux_pkg::OFS_PROG_OUT:  next_rdata = prog_out;
            pin_mux_pkg::OFS_PROG_IN:   next_rdata = pin_in_i;
            default: next_rdata[9:0] = {sel_n, addr_latch, cts_seen};
         endcase
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h0;
      end else if (avs_read_i & ~ack) begin
         avs_readdata_o <= next_rdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // region decode, one comparator per select
   // offset over region size
   genvar gi;
   generate
      for (gi = 0; gi < pin_mux_pkg::REGION_COUNT; gi++) begin : g_region
         region_decode #(
            .ADDR_W (ADDR_W),
            .INDEX  (gi)
         ) u_region (
            .addr_i (bus_addr_i),
            .base_i (periph_base),
            .hit_o  (hit[gi])
         );
      end
   endgenerate
   // space must match the configured one
   // region width fixed by the comparator
   assign any_hit = (|hit) &&
                    (bus_io_i == aux_config_reg[pin_mux_pkg::AUX_SPACE_IO]);
   ////////////////////////////////////////////////////////////////////////
   // address phase tracker
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase <= pin_mux_pkg::PH_IDLE;
      end else begin
         unique case (phase)
            pin_mux_pkg::PH_IDLE:
               if (bus_start_i) phase <= pin_mux_pkg::PH_ADDR;
            pin_mux_pkg::PH_ADDR: phase <= pin_mux_pkg::PH_DATA;
            pin_mux_pkg::PH_DATA:
               if (bus_end_i) phase <= pin_mux_pkg::PH_IDLE;
            default: phase <= pin_mux_pkg::PH_IDLE;
         endcase
      end
   end
   // selects latch in with the address phase
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_n <= '1;
      end else if (bus_start_i) begin
         sel_n <= any_hit ? ~hit : '1;
      end else if (bus_end_i) begin
         sel_n <= '1;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dram_go_o <= 1'b0;
      end else if (bus_start_i) begin
         dram_go_o <= dram_hit_i & ~any_hit;
      end else if (bus_end_i) begin
         dram_go_o <= 1'b0;
      end
   end
   // latched address bits freeze during hold
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_latch <= 2'b00;
      end else if (bus_start_i & ~bus_hold_i) begin
         addr_latch <= bus_addr_i[2:1];
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_float <= 1'b1;
      end else begin
         sel_float <= bus_hold_i;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // serial port 1 flow control
   assign shared_in = pin_in_i[pin_mux_pkg::PIN_SELECT2];
   // rx select bit picks the input role
   assign clear_to_send_port1          = flow_ctl_enable & ~rx_sel & ~shared_in;
   assign receive_enable_request_port1 = flow_ctl_enable & rx_sel & ~shared_in;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cts_seen <= 1'b0;
      end else if (tx_frame_start_i) begin
         cts_seen <= clear_to_send_port1;
      end
   end
   // with flow control on and rx select clear, frame start allowed only with cts asserted
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_allowed_o <= 1'b1;
      end else begin
         tx_allowed_o <= ~flow_ctl_enable | rx_sel | clear_to_send_port1;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_enabled_o <= 1'b1;
      end else begin
         rx_enabled_o <= ~flow_ctl_enable | ~rx_sel |
                         receive_enable_request_port1;
      end
   end
   assign request_to_send_port1  = tx_pending_i;
   assign ready_to_receive_port1 = ~rx_full_i;
   assign shared_out = send_sel ? request_to_send_port1
                                : ready_to_receive_port1;
   ////////////////////////////////////////////////////////////////////////
   // pin function mux (active low pins)
   always_comb begin
      next_fn_out = '1;
      next_fn_oe  = '0;
      // released selects are held weakly high
      next_fn_pu  = '0;
      next_fn_pu[pin_mux_pkg::PIN_SELECT0]  = sel_float;
      next_fn_pu[pin_mux_pkg::PIN_SELECT1]  = sel_float;
      next_fn_out[pin_mux_pkg::PIN_SELECT0] = sel_n[0];
      next_fn_out[pin_mux_pkg::PIN_SELECT1] = sel_n[1];
      next_fn_oe[pin_mux_pkg::PIN_SELECT0]  = ~sel_float;
      next_fn_oe[pin_mux_pkg::PIN_SELECT1]  = ~sel_float;
      // pins 18 and 19 shared with flow control
      if (!flow_ctl_enable) begin
         next_fn_out[pin_mux_pkg::PIN_SELECT2] = sel_n[2];
         next_fn_out[pin_mux_pkg::PIN_SELECT3] = sel_n[3];
         next_fn_oe[pin_mux_pkg::PIN_SELECT2]  = ~sel_float;
         next_fn_oe[pin_mux_pkg::PIN_SELECT3]  = ~sel_float;
         next_fn_pu[pin_mux_pkg::PIN_SELECT2]  = sel_float;
         next_fn_pu[pin_mux_pkg::PIN_SELECT3]  = sel_float;
      end else begin
         next_fn_out[pin_mux_pkg::PIN_SELECT3] = ~shared_out;
         next_fn_oe[pin_mux_pkg::PIN_SELECT3]  = 1'b1;
      end
      if (extended_select_bit) begin
         next_fn_out[pin_mux_pkg::PIN_REGION6] = sel_n[5];
         next_fn_out[pin_mux_pkg::PIN_REGION7] = sel_n[6];
         next_fn_oe[pin_mux_pkg::PIN_REGION6]  = ~sel_float;
         next_fn_oe[pin_mux_pkg::PIN_REGION7]  = ~sel_float;
         next_fn_pu[pin_mux_pkg::PIN_REGION6]  = sel_float;
         next_fn_pu[pin_mux_pkg::PIN_REGION7]  = sel_float;
      end else begin
         next_fn_out[pin_mux_pkg::PIN_REGION6] = addr_latch[0];
         next_fn_out[pin_mux_pkg::PIN_REGION7] = addr_latch[1];
         next_fn_oe[pin_mux_pkg::PIN_REGION6]  = 1'b1;
         next_fn_oe[pin_mux_pkg::PIN_REGION7]  = 1'b1;
      end
   end
   // prog io enable overrides; open drain drives low only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_out_o     <= '1;
         pin_oe_o      <= '0;
         pin_pull_up_o <= pin_mux_pkg::PROG_PULL_RESET;
         pin_pull_dn_o <= ~pin_mux_pkg::PROG_PULL_RESET;
         pin_fn_o      <= ~pin_mux_pkg::PROG_EN_RESET;
      end else begin
         pin_out_o     <= (prog_en & prog_out) | (~prog_en & next_fn_out);
         pin_oe_o      <= (prog_en & ~prog_dir & ~prog_out) |
                          (~prog_en & next_fn_oe);
         pin_pull_up_o <= (prog_en & prog_pull) | (~prog_en & next_fn_pu);
         pin_pull_dn_o <= prog_en & ~prog_pull;
         pin_fn_o      <= ~prog_en;
      end
   end
endmodule : periph_select_pin_mux

/* File: core/pin_mux_pkg.sv */
// Purpose: constants for the peripheral select and shared pin block
// Assumes: 32-bit avalon-mm register port, one 100 MHz clock
// Notes:   offsets are byte addresses of aligned words
package pin_mux_pkg;
   // register byte offsets
   localparam logic [3:0] OFS_PERIPH_BASE = 4'h0;
   localparam logic [3:0] OFS_AUX_CONFIG  = 4'h4;
   localparam logic [3:0] OFS_PROG_EN     = 4'h8;
   localparam logic [3:0] OFS_PROG_DIR    = 4'hc;
   // second bank of offsets, bit 4 of the address set
   localparam logic [3:0] OFS_PROG_PULL   = 4'h0;
   localparam logic [3:0] OFS_PROG_OUT    = 4'h4;
   localparam logic [3:0] OFS_PROG_IN     = 4'h8;
   localparam logic [3:0] OFS_STATUS      = 4'hc;
   // aux config fields
   localparam int AUX_FLOW_CTL_ENABLE   = 0;
   localparam int AUX_RX_ENABLE_SELECT  = 1;
   localparam int AUX_SEND_SELECT       = 2;
   localparam int AUX_EXTENDED_SELECT   = 3;
   localparam int AUX_SPACE_IO          = 4;
   localparam int AUX_WIDTH             = 5;
   localparam logic [4:0] AUX_RESET     = 5'h00;
   // region geometry: 256-byte regions
   localparam int REGION_SHIFT          = 8;
   localparam int REGION_COUNT          = 7;
   // prog io pin numbers that reset to prog io; pins 4 to 9 reset to normal function
   localparam logic [31:0] PROG_EN_RESET   = 32'hfffffc0f;
   localparam logic [31:0] PROG_DIR_RESET  = 32'hffffffff;
   // 1 = pullup, 0 = pulldown; pins 1 and 10 pull down
   localparam logic [31:0] PROG_PULL_RESET = 32'hfffffbfd;
   // shared pin numbers
   localparam int PIN_SELECT2 = 18;
   localparam int PIN_SELECT3 = 19;
   localparam int PIN_REGION6 = 3;
   localparam int PIN_REGION7 = 2;
   localparam int PIN_SELECT0 = 16;
   localparam int PIN_SELECT1 = 17;
   // one-hot states of the address phase tracker
   typedef enum logic [2:0] {
      PH_IDLE  = 3'b001,
      PH_ADDR  = 3'b010,
      PH_DATA  = 3'b100
   } phase_t;
endpackage : pin_mux_pkg

/* File: core/region_decode.sv */
// Purpose: one 256-byte peripheral region comparator
// Assumes: address and base are in the same space
// Notes:   instantiated once per select output
`timescale 1ns/1ns
module region_decode #(
   parameter int ADDR_W = 20,
   parameter int INDEX  = 0
) (
   // address and base
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [ADDR_W-1:0] base_i,
   // match
   output logic                  hit_o
);
   logic [ADDR_W-1:0] offset;
   // offset divided by region size gives the index
   always_comb begin
      offset = addr_i - base_i;
      hit_o  = (addr_i >= base_i) &&
               (offset[ADDR_W-1:pin_mux_pkg::REGION_SHIFT] ==
                (ADDR_W-pin_mux_pkg::REGION_SHIFT)'(INDEX));
   end
endmodule : region_decode

/* File: tb/periph_select_pin_mux_test.sv */
// Purpose: register driven scenarios for the pin block
// Assumes: avalon answers after one wait cycle, pins one edge late
// Notes:   pin 18 is driven by the peer only in flow control tests
`timescale 1ns/1ns
module periph_select_pin_mux_test;
   localparam logic [19:0] BASE = 20'h10000;
   logic        clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic        bus_start_i, bus_io_i, bus_end_i, bus_hold_i, dram_hit_i;
   logic        dram_go_o, tx_pending_i, tx_frame_start_i, rx_full_i;
   logic        tx_allowed_o, rx_enabled_o;
   logic [4:0]  avs_address_i;
   logic [6:0]  sel_n;
   logic [19:0] bus_addr_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, pin_in_i, pin_out_o, rd;
   logic [31:0] pin_oe_o, pin_pull_up_o, pin_pull_dn_o, pin_fn_o;
   logic [31:0] drv_en, drv_val;
   int          err_total, total_checks;
   periph_select_pin_mux #(.ADDR_W(20)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .bus_addr_i(bus_addr_i),
      .bus_start_i(bus_start_i), .bus_io_i(bus_io_i),
      .bus_end_i(bus_end_i), .bus_hold_i(bus_hold_i),
      .dram_hit_i(dram_hit_i), .dram_go_o(dram_go_o),
      .tx_pending_i(tx_pending_i), .tx_frame_start_i(tx_frame_start_i),
      .rx_full_i(rx_full_i), .tx_allowed_o(tx_allowed_o),
      .rx_enabled_o(rx_enabled_o), .pin_in_i(pin_in_i),
      .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
      .pin_pull_up_o(pin_pull_up_o), .pin_pull_dn_o(pin_pull_dn_o),
      .pin_fn_o(pin_fn_o));
   pin_peer peer (.clk_i(clk_i), .out_i(pin_out_o), .oe_i(pin_oe_o),
      .up_i(pin_pull_up_o), .dn_i(pin_pull_dn_o), .drv_en_i(drv_en),
      .drv_val_i(drv_val), .level_o(pin_in_i));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : check
   // master holds the request until waitrequest is sampled low
   task automatic bus_acc(input logic w, input logic [4:0] a,
                          input logic [31:0] d);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus_acc
   task automatic reg_chk(input string n, input logic [4:0] a,
                          input logic [31:0] m, e);
      bus_acc(1'b0, a, 32'h0);
      check(n, e & m, rd & m);
   endtask : reg_chk
   // end the previous bus cycle, then open one at address a
   task automatic cyc(input logic [19:0] a, input logic io);
      @(posedge clk_i);
      bus_end_i <= 1'b1;
      @(posedge clk_i);
      bus_end_i <= 1'b0;
      bus_addr_i <= a;
      bus_io_i <= io;
      bus_start_i <= 1'b1;
      @(posedge clk_i);
      bus_start_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : cyc
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wait_n
   task automatic conclude;
      if (err_total == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // watchdog, the whole sequence needs well under a thousand cycles
   initial begin
      wait_n(20000);
      err_total++;
      conclude();
   end
   initial begin
      {avs_read_i, avs_write_i, bus_start_i, bus_io_i, bus_end_i} = '0;
      {bus_hold_i, dram_hit_i, tx_pending_i, tx_frame_start_i} = '0;
      {rx_full_i, avs_address_i, bus_addr_i, avs_writedata_i} = '0;
      {drv_en, drv_val, err_total, total_checks} = '0;
      rst_i = 1'b1;
      wait_n(6);
      rst_i <= 1'b0;
      wait_n(2);
      check("fn", 32'h3f0, pin_fn_o);
      check("oe", 32'h0, pin_oe_o);
      check("pulldn", 32'h402, pin_pull_dn_o & 32'h403);
      reg_chk("en", 5'h08, '1, 32'hfffffc0f);
      reg_chk("dir", 5'h0c, '1, 32'hffffffff);
      reg_chk("pull", 5'h10, '1, 32'hfffffbfd);
      bus_acc(1'b1, 5'h08, 32'hfcf07c03);
      bus_acc(1'b1, 5'h00, {12'h0, BASE});
      bus_acc(1'b1, 5'h04, 32'h08);
      // overlap: wait states are the far side's business
      dram_hit_i <= 1'b1;
      // top byte of every region, then the top byte of the 256 bytes past region 7
      for (int k = 0; k < 8; k++) begin
         cyc(BASE + 20'(k * 256 + 255), 1'b0);
         sel_n = (k < 7) ? ~(7'h01 << k) : 7'h7f;
         check("pins", {26'h0, sel_n[6:5], sel_n[3:0]}, {26'h0, pin_out_o[2],
            pin_out_o[3], pin_out_o[19:16]});
         check("dram", {31'h0, k == 7}, {31'h0, dram_go_o});
         reg_chk("status", 5'h1c, 32'h3f8, {22'h0, sel_n, 3'h0});
      end
      bus_acc(1'b1, 5'h04, 32'h18);
      cyc(BASE + 20'h1ff, 1'b1);
      check("io sel", 32'h0, {31'h0, pin_out_o[17]});
      bus_hold_i <= 1'b1;
      wait_n(3);
      check("hold oe", 32'h0, {28'h0, pin_oe_o[19:16]});
      check("hold wire", 32'h1, {31'h0, pin_in_i[17]});
      bus_hold_i <= 1'b0;
      bus_acc(1'b1, 5'h04, 32'h00);
      cyc(BASE + 20'h502, 1'b0);
      check("addr", 32'h1, {30'h0, pin_out_o[2], pin_out_o[3]});
      bus_hold_i <= 1'b1;
      wait_n(3);
      check("addr hold", 32'hd, {28'h0, pin_oe_o[3:2], pin_out_o[2],
         pin_out_o[3]});
      bus_hold_i <= 1'b0;
      bus_acc(1'b1, 5'h04, 32'h01);
      cyc(BASE + 20'h200, 1'b0);
      check("no sel2", 32'h0, {31'h0, pin_oe_o[18]});
      check("rtr", 32'h0, {31'h0, pin_out_o[19]});
      rx_full_i <= 1'b1;
      tx_pending_i <= 1'b1;
      drv_en <= 32'h40000;
      wait_n(3);
      check("rtr full", 32'h1, {31'h0, pin_out_o[19]});
      check("cts on", 32'h1, {31'h0, tx_allowed_o});
      drv_val <= 32'h40000;
      wait_n(3);
      check("cts off", 32'h0, {31'h0, tx_allowed_o});
      drv_val <= 32'h0;
      wait_n(2);
      tx_frame_start_i <= 1'b1;
      wait_n(1);
      tx_frame_start_i <= 1'b0;
      drv_val <= 32'h40000;
      reg_chk("cts seen", 5'h1c, 32'h1, 32'h1);
      bus_acc(1'b1, 5'h04, 32'h05);
      wait_n(2);
      check("rts", 32'h0, {31'h0, pin_out_o[19]});
      tx_pending_i <= 1'b0;
      wait_n(3);
      check("rts idle", 32'h1, {31'h0, pin_out_o[19]});
      bus_acc(1'b1, 5'h04, 32'h03);
      drv_val <= 32'h0;
      wait_n(3);
      check("enrx", 32'h1, {31'h0, rx_enabled_o});
      drv_val <= 32'h40000;
      wait_n(3);
      check("enrx off", 32'h0, {31'h0, rx_enabled_o});
      drv_en <= 32'h0;
      bus_acc(1'b1, 5'h0c, 32'hfffeffff);
      bus_acc(1'b1, 5'h14, 32'h0);
      bus_acc(1'b1, 5'h08, 32'hfcf17c03);
      wait_n(2);
      check("prog pin", 32'h2, {29'h0, pin_fn_o[16], pin_oe_o[16],
         pin_out_o[16]});
      reg_chk("pin in", 5'h18, 32'h10000, 32'h0);
      bus_acc(1'b1, 5'h05, 32'h1f);
      reg_chk("aux kept", 5'h04, 32'h1f, 32'h03);
      conclude();
   end
endmodule : periph_select_pin_mux_test

/* File: tb/pin_mux_checker.sv */
// Purpose: port checks for the peripheral select pin block
// Assumes: aux config is shadowed from completed register writes
// Notes:   pin numbers follow the package shared pin map
`timescale 1ns/1ns
module pin_mux_checker #(
   parameter int ADDR_W = 20
) (
   // clock and reset
   input wire logic              clk_i,
   input wire logic              rst_i,
   // register port
   input wire logic [4:0]        avs_address_i,
   input wire logic              avs_write_i,
   input wire logic [31:0]       avs_writedata_i,
   input wire logic              avs_waitrequest_o,
   // bus and serial side
   input wire logic [ADDR_W-1:0] bus_addr_i,
   input wire logic              bus_start_i,
   input wire logic              bus_end_i,
   input wire logic              bus_hold_i,
   input wire logic              tx_pending_i,
   input wire logic              rx_full_i,
   input wire logic              tx_allowed_o,
   input wire logic              rx_enabled_o,
   // pins
   input wire logic [31:0]       pin_in_i,
   input wire logic [31:0]       pin_out_o,
   input wire logic [31:0]       pin_oe_o,
   input wire logic [31:0]       pin_fn_o
);
   logic [4:0] aux;
   // shadow of aux config: the pin modes are not visible at the ports
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) aux <= 5'h00;
      else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h04)
         aux <= avs_writedata_i[4:0];
   end
   // mode qualifiers, a pin taken as prog io drops out of every check
   wire cts_m  = aux[0] && !aux[1] && pin_fn_o[18];
   wire enrx_m = aux[0] && aux[1] && pin_fn_o[18];
   wire rts_m  = aux[0] && aux[2] && pin_fn_o[19];
   wire rtr_m  = aux[0] && !aux[2] && pin_fn_o[19];
   wire addr_m = !aux[3] && pin_fn_o[3] && pin_fn_o[2];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   a_sel_float: assert property (
      bus_hold_i[*3] |-> (pin_oe_o[17:16] & pin_fn_o[17:16]) == 2'b00)
      else $error("select driven during hold");
   a_sel_clear: assert property (
      bus_end_i && !bus_hold_i |-> ##2
      (pin_out_o[17:16] | ~pin_fn_o[17:16]) == 2'b11)
      else $error("select not cleared after cycle end");
   a_rts_busy: assert property (
      (rts_m && tx_pending_i)[*3] |-> !pin_out_o[19])
      else $error("send request not asserted");
   a_rts_idle: assert property (
      (rts_m && !tx_pending_i)[*3] |-> pin_out_o[19])
      else $error("send request asserted while empty");
   a_rtr_level: assert property (
      (rtr_m && $stable(rx_full_i))[*3] |-> pin_out_o[19] == rx_full_i)
      else $error("receive ready wrong");
   a_enrx_follow: assert property (
      (enrx_m && $stable(pin_in_i[18]))[*3] |->
      rx_enabled_o == !pin_in_i[18])
      else $error("receiver enable does not follow request");
   a_cts_gate: assert property (
      (cts_m && pin_in_i[18])[*3] |-> !tx_allowed_o)
      else $error("frame allowed without clear to send");
   a_addr_bits: assert property (
      addr_m && bus_start_i && !bus_hold_i |-> ##2
      pin_out_o[3:2] == {$past(bus_addr_i[1], 2), $past(bus_addr_i[2], 2)})
      else $error("latched address bits wrong");
   a_addr_keep: assert property (
      (addr_m && bus_hold_i)[*3] |=>
      pin_oe_o[3] && pin_oe_o[2] && $stable(pin_out_o[3:2]))
      else $error("latched address bits lost in hold");
   // main scenarios reached
   c_hold: cover property (bus_hold_i[*3]);
   c_cts: cover property (cts_m && !pin_in_i[18]);
   c_addr: cover property (addr_m && bus_start_i);
endmodule : pin_mux_checker

bind periph_select_pin_mux pin_mux_checker #(.ADDR_W(ADDR_W)) chk (
   .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_waitrequest_o(avs_waitrequest_o), .bus_addr_i(bus_addr_i),
   .bus_start_i(bus_start_i), .bus_end_i(bus_end_i),
   .bus_hold_i(bus_hold_i), .tx_pending_i(tx_pending_i),
   .rx_full_i(rx_full_i), .tx_allowed_o(tx_allowed_o),
   .rx_enabled_o(rx_enabled_o), .pin_in_i(pin_in_i),
   .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_fn_o(pin_fn_o));

/* File: tb/pin_peer.sv */
// Purpose: pin wires with the peripherals and serial peer behind them
// Assumes: the peer drives a pin only while the design leaves it
// Notes:   a pin with no driver and no pull toggles, so no stale value
`timescale 1ns/1ns
module pin_peer (
   // clock
   input  wire logic        clk_i,
   // design side
   input  wire logic [31:0] out_i,
   input  wire logic [31:0] oe_i,
   input  wire logic [31:0] up_i,
   input  wire logic [31:0] dn_i,
   // peer drive, low is asserted
   input  wire logic [31:0] drv_en_i,
   input  wire logic [31:0] drv_val_i,
   // resolved wires
   output logic      [31:0] level_o
);
   logic flip = 1'b0;
   always_ff @(posedge clk_i) flip <= !flip;
   // wire level: design, then peer, then pull
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         if (oe_i[i]) level_o[i] = out_i[i];
         else if (drv_en_i[i]) level_o[i] = drv_val_i[i];
         else if (up_i[i] || dn_i[i]) level_o[i] = up_i[i];
         else level_o[i] = flip;
      end
   end
endmodule : pin_peer
